// File: src/tdcewf_formatter.sv
// level-1 and readout word formatter with its apb control registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tdcewf_formatter
  import tdcewf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hit_valid,
  input wire tdcewf_hit_type hit,
  input wire logic sep_valid,
  input wire logic [8:0] fill_count,
  output logic l1_valid,
  output logic [L1_WIDTH-1:0] l1_word,
  input wire logic ro_req_valid,
  input wire tdcewf_ro_req_type ro_req,
  input wire logic ro_fifo_full,
  input wire logic l1_near_full,
  input wire logic trig_near_full,
  output logic ro_valid,
  output logic [RO_WIDTH-1:0] ro_word,
  output logic ro_strip
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic payload_fault(input logic [31:0] p);
    payload_fault = p[L1_FAULT_BIT] | p[L1_REJECT_BIT]; // RL17
  endfunction : payload_fault

  function automatic logic is_header_kind(input tdcewf_kind_type k);
    is_header_kind = (k == KIND_HEADER) || (k == KIND_LOST_HEADER);
  endfunction : is_header_kind

  function automatic logic is_trailer_kind(input tdcewf_kind_type k);
    is_trailer_kind = (k == KIND_TRAILER) || (k == KIND_LOST_TRAILER);
  endfunction : is_trailer_kind

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  logic [8:0] ctrl;
  logic sticky;
  logic [4:0] last_error;
  logic [15:0] word_count;
  logic [31:0] read_value;
  logic addr_hit;

  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire ctrl_write = apb_done & pwrite & (paddr == ADDR_CTRL);

  always_comb begin
    read_value = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == ADDR_CTRL) begin
      read_value = {23'h000000, ctrl};
    end else if (paddr == ADDR_STATUS) begin
      read_value = {26'h0000000, last_error, sticky};
    end else if (paddr == ADDR_COUNT) begin
      read_value = {16'h0000, word_count};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // writes to read-only words are accepted and ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      if (apb_setup & ~pwrite) begin
        prdata <= read_value;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl <= pwdata[8:0];
    end
  end

  wire pair_mode = ctrl[CTRL_PAIR];
  wire relative_mode = ctrl[CTRL_RELATIVE];
  wire match_mode = ctrl[CTRL_MATCH];
  wire odd_parity = ctrl[CTRL_ODD_PARITY];
  wire drop_on_level1_near_full = ctrl[CTRL_L1FULL_REJECT];

  // ------------------------------------------------------------
  // level-1 word
  // ------------------------------------------------------------
  wire ovf_start = fill_count >= OVF_START_FILL; // RL1
  wire ovf_recovered = fill_count < OVF_RECOVER_FILL;
  // set wins over recovery in the same cycle
  wire next_sticky = ovf_start | (sticky & ~ovf_recovered); // RL2

  wire hit_fault = hit.select_error | hit.coarse_error; // RL8
  wire hit_reject = pair_mode ? (hit.reject_first | hit.reject_second) : hit.reject_first; // RL7
  wire [7:0] pair_width = hit.width_over ? WIDTH_ALL_ONES :
                          hit.width_under ? WIDTH_ALL_ZERO : hit.width; // RL6
  wire [31:0] pair_payload = {hit_fault, hit_reject, hit.channel, pair_width, hit.edge_time}; // RL6
  wire [31:0] single_payload = {hit_fault, hit_reject, hit.channel, L1_GAP_ZERO,
                                hit.edge_leading, hit.edge_time}; // RL5 RL22
  // separator takes the slot; a hit offered with it is not stored
  wire [31:0] l1_payload = sep_valid ? 32'h0000_0000 : (pair_mode ? pair_payload : single_payload); // RL3
  wire [34:0] l1_body = {sep_valid, next_sticky, ovf_start, l1_payload}; // RL3
  wire l1_parity = (^l1_body) ^ odd_parity; // RL4
  wire [L1_WIDTH-1:0] next_l1_word = {l1_parity, l1_body}; // RL1 RL4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky <= 1'b0;
      l1_valid <= 1'b0;
      l1_word <= 36'h0_0000_0000;
    end else begin
      sticky <= next_sticky; // RL2
      l1_valid <= hit_valid | sep_valid; // RL25
      if (hit_valid | sep_valid) begin
        l1_word <= next_l1_word; // RL25
      end
    end
  end

  // ------------------------------------------------------------
  // readout word
  // ------------------------------------------------------------
  wire [31:0] pl = ro_req.l1_payload;
  wire full_rejected = ctrl[CTRL_ROFULL_REJECT] & ro_fifo_full &
                       ((drop_on_level1_near_full & l1_near_full) |
                        (ctrl[CTRL_TRFULL_REJECT] & trig_near_full) |
                        (~drop_on_level1_near_full & ~ctrl[CTRL_TRFULL_REJECT])); // RL13
  wire [4:0] error_field = {~match_mode & pl[L1_REJECT_BIT],
                            match_mode & pl[L1_FAULT_BIT],
                            match_mode & full_rejected,
                            match_mode & ro_req.trigger_lost,
                            match_mode & ro_req.l1_overflow}; // RL12 RL13 RL14
  wire single_edge = pl[L1_EDGE_BIT]; // RL17

  logic [3:0] ro_type;
  logic [23:0] ro_body;

  always_comb begin
    ro_type = TYPE_SEPARATOR;
    ro_body = 24'h000000;
    case (ro_req.kind)
      KIND_HEADER: begin
        ro_type = TYPE_HEADER; // RL9
        ro_body = {ro_req.event_id, ro_req.bunch_id};
      end
      KIND_TRAILER: begin
        ro_type = TYPE_TRAILER; // RL9
        ro_body = {ro_req.event_id, ro_req.bunch_id};
      end
      KIND_LOST_HEADER: begin
        ro_type = TYPE_HEADER; // RL10
        ro_body = {ro_req.lost_id, ro_req.trig_data};
      end
      KIND_LOST_TRAILER: begin
        ro_type = TYPE_TRAILER; // RL10
        ro_body = {ro_req.lost_id, 12'h000};
      end
      KIND_ERROR: begin
        ro_type = TYPE_ERROR; // RL11
        ro_body = {10'h000, error_field, 9'h000};
      end
      KIND_MASK: begin
        ro_type = TYPE_MASK; // RL15
        ro_body = ro_req.mask_flags;
      end
      KIND_SINGLE: begin
        ro_type = TYPE_SINGLE;
        if (relative_mode) begin
          ro_body = {pl[29:25], single_edge, payload_fault(pl), ro_req.coarse_rel, pl[4:0]}; // RL18
        end else begin
          ro_body = {5'h00, single_edge, payload_fault(pl), pl[16:0]}; // RL16 RL17
        end
      end
      KIND_COMBINED: begin
        ro_type = TYPE_COMBINED;
        if (relative_mode) begin
          ro_body = {pl[29:17], ro_req.coarse_rel[5:0], pl[4:0]}; // RL20
        end else begin
          ro_body = {pl[29:17], pl[10:0]}; // RL19
        end
      end
      KIND_SEPARATOR: begin
        ro_type = TYPE_SEPARATOR; // RL21
        ro_body = {12'h000, ro_req.trig_data};
      end
      default: begin
        ro_type = TYPE_SEPARATOR;
        ro_body = 24'h000000;
      end
    endcase
  end

  wire ro_parity = (^{ro_type, ro_body}) ^ odd_parity; // RL24
  wire [RO_WIDTH-1:0] next_ro_word = {ro_parity, ro_type, ro_body}; // RL9
  // disabled headers and trailers still go out, only marked for removal at readout
  wire next_ro_strip = (is_header_kind(ro_req.kind) & ~ctrl[CTRL_HEADER_OUT]) |
                       (is_trailer_kind(ro_req.kind) & ~ctrl[CTRL_TRAILER_OUT]); // RL23

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro_valid <= 1'b0;
      ro_word <= 29'h0000_0000;
      ro_strip <= 1'b0;
      word_count <= 16'h0000;
      last_error <= 5'h00;
    end else begin
      ro_valid <= ro_req_valid; // RL25 RL23
      if (ro_req_valid) begin
        ro_word <= next_ro_word;
        ro_strip <= next_ro_strip;
        word_count <= word_count + 16'h0001;
      end
      if (ro_req_valid && ro_req.kind == KIND_ERROR) begin
        last_error <= error_field;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ovf_start_flag: assert property ( // RL1
    (hit_valid && fill_count >= OVF_START_FILL) |=> l1_valid && l1_word[L1_OVF_BIT])
    else $error("overflow start flag missing");

  a_sticky_hold: assert property ( // RL2
    (hit_valid && sticky && fill_count >= OVF_RECOVER_FILL) |=> l1_word[L1_STICKY_BIT])
    else $error("sticky overflow dropped early");

  a_sticky_clear: assert property ( // RL2
    (hit_valid && fill_count < OVF_RECOVER_FILL) |=> !l1_word[L1_STICKY_BIT])
    else $error("sticky overflow not recovered");

  a_sep_zero: assert property ( // RL3
    sep_valid |=> l1_word[L1_SEP_BIT] && l1_word[31:0] == 32'h0000_0000)
    else $error("separator entry not clean");

  a_l1_parity: assert property ( // RL4
    l1_valid |-> (^l1_word) == odd_parity)
    else $error("level-1 parity wrong");

  a_pair_reject: assert property ( // RL7
    (hit_valid && !sep_valid && pair_mode && hit.reject_second) |=> l1_word[L1_REJECT_BIT])
    else $error("paired reject not merged");

  a_hit_fault: assert property ( // RL8
    (hit_valid && !sep_valid) |=> l1_word[L1_FAULT_BIT] == $past(hit.select_error | hit.coarse_error))
    else $error("fault flag wrong");

  a_header_ids: assert property ( // RL9
    (ro_req_valid && ro_req.kind == KIND_HEADER) |=>
      ro_valid && ro_word[27:24] == TYPE_HEADER && ro_word[23:12] == $past(ro_req.event_id))
    else $error("header word wrong");

  a_error_nomatch: assert property ( // RL12
    (ro_req_valid && ro_req.kind == KIND_ERROR && !match_mode) |=>
      ro_word[12:9] == 4'h0 && ro_word[8:0] == 9'h000 && ro_word[23:14] == 10'h000)
    else $error("error word leaks matching bits");

  a_ro_parity: assert property ( // RL24
    ro_valid |-> (^ro_word) == odd_parity)
    else $error("readout parity wrong");

  a_strip_flag: assert property ( // RL23
    (ro_req_valid && ro_req.kind == KIND_TRAILER && !ctrl[CTRL_TRAILER_OUT]) |=> ro_valid && ro_strip)
    else $error("disabled trailer not written or not marked");

  a_trailer_ids: assert property ( // RL9
    (ro_req_valid && ro_req.kind == KIND_TRAILER) |=>
      ro_word[27:24] == TYPE_TRAILER && ro_word[11:0] == $past(ro_req.bunch_id))
    else $error("trailer word wrong");

  a_lost_header: assert property ( // RL10
    (ro_req_valid && ro_req.kind == KIND_LOST_HEADER) |=>
      ro_word[23:0] == $past({ro_req.lost_id, ro_req.trig_data}))
    else $error("lost header body wrong");

  a_lost_trailer: assert property ( // RL10
    (ro_req_valid && ro_req.kind == KIND_LOST_TRAILER) |=>
      ro_word[27:24] == TYPE_TRAILER && ro_word[11:0] == 12'h000)
    else $error("lost trailer body wrong");

  a_error_frame: assert property ( // RL11
    (ro_req_valid && ro_req.kind == KIND_ERROR) |=>
      ro_word[27:24] == TYPE_ERROR && ro_word[23:14] == 10'h000 && ro_word[8:0] == 9'h000)
    else $error("error word frame wrong");

  a_error_causes: assert property ( // RL12
    (ro_req_valid && ro_req.kind == KIND_ERROR && match_mode) |=>
      ro_word[10:9] == $past({ro_req.trigger_lost, ro_req.l1_overflow}))
    else $error("overflow or lost trigger not reported");

  a_full_reject: assert property ( // RL13
    (ro_req_valid && ro_req.kind == KIND_ERROR && !ro_fifo_full) |=> !ro_word[11])
    else $error("full rejection without full fifo");

  a_error_fault: assert property ( // RL14
    (ro_req_valid && ro_req.kind == KIND_ERROR && match_mode) |=>
      ro_word[12] == $past(pl[L1_FAULT_BIT]) && !ro_word[13])
    else $error("fault bit wrong under matching");

  a_mask_word: assert property ( // RL15
    (ro_req_valid && ro_req.kind == KIND_MASK) |=>
      ro_word[27:24] == TYPE_MASK && ro_word[23:0] == $past(ro_req.mask_flags))
    else $error("mask word wrong");

  a_single_abs: assert property ( // RL16
    (ro_req_valid && ro_req.kind == KIND_SINGLE && !relative_mode) |=>
      ro_word[23:19] == 5'h00 && ro_word[16:0] == $past(pl[16:0]))
    else $error("absolute single word wrong");

  a_single_flags: assert property ( // RL17
    (ro_req_valid && ro_req.kind == KIND_SINGLE) |=>
      ro_word[18] == $past(pl[L1_EDGE_BIT]) && ro_word[17] == $past(pl[31] | pl[30]))
    else $error("single edge or fault bit wrong");

  a_single_rel: assert property ( // RL18
    (ro_req_valid && ro_req.kind == KIND_SINGLE && relative_mode) |=>
      ro_word[23:19] == $past(pl[29:25]) && ro_word[16:5] == $past(ro_req.coarse_rel))
    else $error("relative single word wrong");

  a_comb_abs: assert property ( // RL19
    (ro_req_valid && ro_req.kind == KIND_COMBINED && !relative_mode) |=>
      ro_word[27:24] == TYPE_COMBINED && ro_word[23:0] == $past({pl[29:17], pl[10:0]}))
    else $error("absolute combined word wrong");

  a_comb_rel: assert property ( // RL20
    (ro_req_valid && ro_req.kind == KIND_COMBINED && relative_mode) |=>
      ro_word[10:5] == $past(ro_req.coarse_rel[5:0]) && ro_word[4:0] == $past(pl[4:0]))
    else $error("relative combined word wrong");

  a_sep_word: assert property ( // RL21
    (ro_req_valid && ro_req.kind == KIND_SEPARATOR) |=>
      ro_word[27:24] == TYPE_SEPARATOR && ro_word[23:0] == $past({12'h000, ro_req.trig_data}))
    else $error("separator word wrong");

  a_edge_type: assert property ( // RL22
    (hit_valid && !sep_valid && !pair_mode) |=>
      l1_word[L1_EDGE_BIT] == $past(hit.edge_leading) && l1_word[24:18] == L1_GAP_ZERO)
    else $error("edge type or gap wrong");

  a_pair_width: assert property ( // RL6
    (hit_valid && !sep_valid && pair_mode && hit.width_over) |=> l1_word[24:17] == WIDTH_ALL_ONES)
    else $error("width overflow not all ones");

  a_ro_latency: assert property ( // RL25
    ro_req_valid |=> ro_valid)
    else $error("readout word late");

  a_l1_latency: assert property ( // RL25
    (hit_valid || sep_valid) |=> l1_valid)
    else $error("level-1 word late");

endmodule : tdcewf_formatter

// File: src/tdcewf_pkg.sv
// constants, field layouts and carrier types of the event word formatter
// ----------------------------------------------------------------------
// Function
// RL1: level-1 word is 36 bits; bit 32 flags fill count of 253 or more.
// RL2: bit 33 sticks at one from overflow start until fill drops below 251.
// RL3: bit 34 marks a separator entry, whose lower 32 bits are zero.
// RL4: bit 35 is parity over bits 34 down to 0.
// RL5: pairing off packs fault, reject, channel, zeros, edge type, edge time.
// RL6: pairing on packs width and leading time; overflow all ones, underflow zeros.
// RL7: reject flag is OR of both rejects when pairing, else first reject.
// RL8: fault flag is OR of selection error and coarse counter error.
// RL9: readout word 29 bits, parity 28, type 27:24; header and trailer carry ids.
// RL10: lost header/trailer carry lost id; header adds trigger data, trailer zeros.
// RL11: error word type 0110, error field in 13:9, other bits zero.
// RL12: error bits 0 and 1 report overflow and lost trigger under matching only.
// RL13: error bit 2 reports full rejection under matching with selected near-full.
// RL14: error bit 3 is fault under matching; bit 4 is reject without matching.
// RL15: mask word type 0010 carries 24 channel flags in 23:0.
// RL16: absolute single word: type 0011, zeros, edge type, fault, payload 16:0.
// RL17: single fault is payload 31 OR 30; edge type copies payload 17.
// RL18: relative single word carries channel, 12-bit relative coarse, payload 4:0.
// RL19: absolute combined word: type 0100, payload 29:17 and payload 10:0.
// RL20: relative combined word: 6-bit relative coarse in 10:5, payload 4:0.
// RL21: separator word: type 0111, zeros in 23:12, trigger data in 11:0.
// RL22: pairing off edge type is zero for trailing and one for leading.
// RL23: headers and trailers always written; disabled ones only flagged for readout.
// RL24: readout parity covers bits 27:0, even unless odd parity is selected.
// RL25: every word is formatted in one cycle, available the cycle after its source.
// ----------------------------------------------------------------------
package tdcewf_pkg;

  // ------------------------------------------------------------
  // level-1 word layout
  // ------------------------------------------------------------
  localparam int L1_WIDTH = 36;
  localparam int L1_PARITY_BIT = 35;
  localparam int L1_SEP_BIT = 34;
  localparam int L1_STICKY_BIT = 33;
  localparam int L1_OVF_BIT = 32;
  localparam int L1_FAULT_BIT = 31;
  localparam int L1_REJECT_BIT = 30;
  localparam int L1_EDGE_BIT = 17;
  localparam logic [8:0] OVF_START_FILL = 9'h0FD;
  localparam logic [8:0] OVF_RECOVER_FILL = 9'h0FB;
  localparam logic [7:0] WIDTH_ALL_ONES = 8'hFF;
  localparam logic [7:0] WIDTH_ALL_ZERO = 8'h00;
  localparam logic [6:0] L1_GAP_ZERO = 7'h00;

  // ------------------------------------------------------------
  // readout word layout
  // ------------------------------------------------------------
  localparam int RO_WIDTH = 29;
  localparam int RO_PARITY_BIT = 28;
  localparam logic [3:0] TYPE_HEADER = 4'hA;
  localparam logic [3:0] TYPE_TRAILER = 4'hC;
  localparam logic [3:0] TYPE_ERROR = 4'h6;
  localparam logic [3:0] TYPE_MASK = 4'h2;
  localparam logic [3:0] TYPE_SINGLE = 4'h3;
  localparam logic [3:0] TYPE_COMBINED = 4'h4;
  localparam logic [3:0] TYPE_SEPARATOR = 4'h7;

  // ------------------------------------------------------------
  // register map and control bits
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam int CTRL_PAIR = 0;
  localparam int CTRL_RELATIVE = 1;
  localparam int CTRL_MATCH = 2;
  localparam int CTRL_ROFULL_REJECT = 3;
  localparam int CTRL_L1FULL_REJECT = 4;
  localparam int CTRL_TRFULL_REJECT = 5;
  localparam int CTRL_HEADER_OUT = 6;
  localparam int CTRL_TRAILER_OUT = 7;
  localparam int CTRL_ODD_PARITY = 8;
  localparam logic [8:0] CTRL_RESET = 9'h0C4;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef enum logic [8:0] {
    KIND_HEADER = 9'h001,
    KIND_TRAILER = 9'h002,
    KIND_LOST_HEADER = 9'h004,
    KIND_LOST_TRAILER = 9'h008,
    KIND_ERROR = 9'h010,
    KIND_MASK = 9'h020,
    KIND_SINGLE = 9'h040,
    KIND_COMBINED = 9'h080,
    KIND_SEPARATOR = 9'h100
  } tdcewf_kind_type;

  typedef struct packed {
    logic select_error;
    logic coarse_error;
    logic reject_first;
    logic reject_second;
    logic [4:0] channel;
    logic edge_leading;
    logic [16:0] edge_time;
    logic width_over;
    logic width_under;
    logic [7:0] width;
  } tdcewf_hit_type;

  typedef struct packed {
    tdcewf_kind_type kind;
    logic [11:0] event_id;
    logic [11:0] bunch_id;
    logic [11:0] lost_id;
    logic [11:0] trig_data;
    logic [23:0] mask_flags;
    logic [31:0] l1_payload;
    logic [11:0] coarse_rel;
    logic l1_overflow;
    logic trigger_lost;
  } tdcewf_ro_req_type;

endpackage : tdcewf_pkg

// File: verification/tdcewf_far_model.sv
// far-side model: trigger matching issuing readout requests
`timescale 1ns/1ps
module tdcewf_far_model
  import tdcewf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic ro_req_valid,
  output tdcewf_ro_req_type ro_req,
  output logic ro_fifo_full,
  output logic l1_near_full,
  output logic trig_near_full
);
  // ------------------------------------------------------------
  // request queue
  // ------------------------------------------------------------
  tdcewf_ro_req_type pend_q[$];
  logic [2:0] flag_q[$];
  logic gap;

  task automatic send(input tdcewf_ro_req_type q, input logic [2:0] f);
    pend_q.push_back(q);
    flag_q.push_back(f);
  endtask : send

  // idle fields toggle each cycle so a stale word never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro_req_valid <= 1'b0;
      ro_req <= '0;
      {ro_fifo_full, l1_near_full, trig_near_full} <= 3'h0;
      gap <= 1'b0;
    end else if (pend_q.size() != 0 && !(slow && gap)) begin
      ro_req_valid <= 1'b1;
      ro_req <= pend_q.pop_front();
      {ro_fifo_full, l1_near_full, trig_near_full} <= flag_q.pop_front();
      gap <= ~gap;
    end else begin
      ro_req_valid <= 1'b0;
      ro_req <= ~ro_req;
      gap <= ~gap;
    end
  end
endmodule : tdcewf_far_model

// File: verification/testbench.sv
// self-checking bench of the event word formatter
`timescale 1ns/1ps
module testbench
  import tdcewf_pkg::*;
();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hit_valid = 0, sep_valid = 0, slow = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h39;
  logic pready, pslverr, l1_valid, ro_valid, ro_strip, ro_req_valid, ro_fifo_full, l1_near_full, trig_near_full;
  tdcewf_hit_type hit = '0;
  tdcewf_ro_req_type ro_req;
  logic [8:0] fill_count = '0, ctrl = 9'h0C4;
  logic [35:0] l1_word;
  logic [28:0] ro_word;
  logic sticky = 0, req_d = 0, hv_d = 0;
  logic [15:0] nro = '0;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [35:0] l1_q[$];
  logic [29:0] ro_q[$];

  tdcewf_formatter dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hit_valid(hit_valid), .hit(hit), .sep_valid(sep_valid), .fill_count(fill_count), .l1_valid(l1_valid),
    .l1_word(l1_word), .ro_req_valid(ro_req_valid), .ro_req(ro_req), .ro_fifo_full(ro_fifo_full),
    .l1_near_full(l1_near_full), .trig_near_full(trig_near_full), .ro_valid(ro_valid), .ro_word(ro_word),
    .ro_strip(ro_strip));
  tdcewf_far_model far (.pclk(pclk), .presetn(presetn), .slow(slow), .ro_req_valid(ro_req_valid),
    .ro_req(ro_req), .ro_fifo_full(ro_fifo_full), .l1_near_full(l1_near_full), .trig_near_full(trig_near_full));

  initial forever #50 pclk = ~pclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [35:0] s, input logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    {paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic l1_send(input tdcewf_hit_type h, input logic sep, input logic [8:0] f);
    logic [31:0] p;
    logic [7:0] w;
    logic flt, rej, ovf;
    flt = h.select_error | h.coarse_error;
    rej = ctrl[0] ? h.reject_first | h.reject_second : h.reject_first;
    w = h.width_over ? WIDTH_ALL_ONES : (h.width_under ? WIDTH_ALL_ZERO : h.width);
    p = ctrl[0] ? {flt, rej, h.channel, w, h.edge_time} :
        {flt, rej, h.channel, L1_GAP_ZERO, h.edge_leading, h.edge_time};
    ovf = f >= OVF_START_FILL;
    sticky = ovf | (sticky & (f >= OVF_RECOVER_FILL));
    p = sep ? 32'h0 : p;
    l1_q.push_back({ctrl[8] ^ (^{sep, sticky, ovf, p}), sep, sticky, ovf, p});
    @(posedge pclk);
    {hit, hit_valid, sep_valid, fill_count} <= {h, !sep, sep, f};
    @(posedge pclk);
    {hit_valid, sep_valid} <= 2'b00;
  endtask : l1_send

  task automatic ro_send(input tdcewf_ro_req_type q, input logic [2:0] f);
    logic [27:0] b;
    logic [31:0] p;
    logic [4:0] e;
    logic m, s;
    m = ctrl[CTRL_MATCH];
    p = q.l1_payload;
    s = 1'b0;
    e = {~m & p[30], m & p[31], m & ctrl[3] & f[2] & (ctrl[4] & f[1] | ctrl[5] & f[0] | ~ctrl[4] & ~ctrl[5]),
         m & q.trigger_lost, m & q.l1_overflow};
    case (q.kind)
      KIND_HEADER: {s, b} = {~ctrl[6], TYPE_HEADER, q.event_id, q.bunch_id};
      KIND_TRAILER: {s, b} = {~ctrl[7], TYPE_TRAILER, q.event_id, q.bunch_id};
      KIND_LOST_HEADER: {s, b} = {~ctrl[6], TYPE_HEADER, q.lost_id, q.trig_data};
      KIND_LOST_TRAILER: {s, b} = {~ctrl[7], TYPE_TRAILER, q.lost_id, 12'h000};
      KIND_ERROR: b = {TYPE_ERROR, 10'h000, e, 9'h000};
      KIND_MASK: b = {TYPE_MASK, q.mask_flags};
      KIND_SINGLE: b = ctrl[1] ? {TYPE_SINGLE, p[29:25], p[17], p[31] | p[30], q.coarse_rel, p[4:0]} :
                   {TYPE_SINGLE, 5'h00, p[17], p[31] | p[30], p[16:0]};
      KIND_COMBINED: b = ctrl[1] ? {TYPE_COMBINED, p[29:17], q.coarse_rel[5:0], p[4:0]} :
                     {TYPE_COMBINED, p[29:17], p[10:0]};
      default: b = {TYPE_SEPARATOR, 12'h000, q.trig_data};
    endcase
    ro_q.push_back({s, ctrl[8] ^ (^b), b});
    nro++;
    far.send(q, f);
  endtask : ro_send

  // ------------------------------------------------------------
  // output watcher
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (l1_valid === 1'b1) check(l1_word, l1_q.size() ? l1_q.pop_front() : ~l1_word);
    if (ro_valid === 1'b1) check({ro_strip, ro_word}, ro_q.size() ? ro_q.pop_front() : ~{ro_strip, ro_word});
    if (presetn === 1'b1) begin
      check(ro_valid, req_d);
      check(l1_valid, hv_d);
    end
    req_d = ro_req_valid;
    hv_d = hit_valid | sep_valid;
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] r, r2;
    logic e;
    tdcewf_hit_type h;
    tdcewf_ro_req_type q;
    logic [8:0] fills[7] = '{9'h000, 9'h0FD, 9'h0FC, 9'h0FB, 9'h0FA, 9'h0FF, 9'h064};
    tdcewf_kind_type kinds[9] = '{KIND_HEADER, KIND_TRAILER, KIND_LOST_HEADER, KIND_LOST_TRAILER, KIND_ERROR,
                                  KIND_MASK, KIND_SINGLE, KIND_COMBINED, KIND_SEPARATOR};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(ADDR_CTRL, 1'b0, 32'h0, r, e);
    check(r, {23'h0, CTRL_RESET});
    apb(12'h010, 1'b0, 32'h0, r, e);
    check({e, r}, 33'h100000000);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      ctrl = {seed[8:3], k[2:0]};
      slow <= k[0];
      apb(ADDR_CTRL, 1'b1, {23'h0, ctrl}, r, e);
      apb(ADDR_CTRL, 1'b0, 32'h0, r, e);
      check(r, {23'h0, ctrl});
      for (int i = 0; i < 20; i++) begin
        seed = lfsr(seed);
        r = seed;
        seed = lfsr(seed);
        h = {r, seed[4:0]};
        if (h.width_over) h.width_under = 1'b0;
        l1_send(h, i % 5 == 4, fills[i % 7]);
      end
      for (int i = 0; i < 27; i++) begin
        seed = lfsr(seed);
        r = seed;
        seed = lfsr(seed);
        r2 = seed;
        seed = lfsr(seed);
        q = {r, r2, seed, lfsr(seed)};
        q.kind = kinds[i % 9];
        ro_send(q, r[2:0]);
      end
      for (int n = 0; n < 200 && (ro_q.size() || l1_q.size()); n++) @(posedge pclk);
    end
    apb(ADDR_COUNT, 1'b0, 32'h0, r, e);
    check(r[15:0], nro);
    apb(ADDR_STATUS, 1'b0, 32'h0, r, e);
    check(r[0], sticky);
    report_and_stop();
  end
endmodule : testbench
